// [rtl/mrr_pkg.sv]
/*
 motion report register group: shared register map, field layout,
 reset values, full-scale limits and the carrier structs.
 assumes a serial-port front end on the same clock that turns each
 register access into a one-cycle request.
*/
package mrr_pkg;

   // register addresses
   localparam logic [6:0] ADDR_STATUS = 7'h02;
   localparam logic [6:0] ADDR_X_DISP = 7'h03;
   localparam logic [6:0] ADDR_Y_DISP = 7'h04;
   localparam logic [6:0] ADDR_QUALITY = 7'h05;
   localparam logic [6:0] ADDR_PIX_SUM = 7'h06;
   localparam logic [6:0] ADDR_BRIGHT = 7'h07;
   localparam logic [6:0] ADDR_RSVD_A = 7'h08;
   localparam logic [6:0] ADDR_RSVD_B = 7'h09;
   localparam logic [6:0] ADDR_FLUSH = 7'h12;

   // status byte field positions
   localparam int BIT_PENDING = 7;
   localparam int BIT_OVERFLOW = 4;
   localparam int BIT_CPI = 0;

   // reset and fill values
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [1:0] BRIGHT_PAD = 2'h0;

   // eight-bit report limits
   localparam logic signed [7:0] DISP_MAX = 8'sh7F;
   localparam logic signed [7:0] DISP_MIN = 8'sh80;

   // frame statistic ceilings
   localparam logic [7:0] QUALITY_MAX = 8'hA9;
   localparam logic [7:0] PIX_SUM_MAX = 8'hDD;

   // one register access from the serial front end
   typedef struct packed {
      logic rd;
      logic wr;
      logic [6:0] addr;
      logic [7:0] wdata;
   } mrr_req_s;

   // results of one navigation frame
   typedef struct packed {
      logic valid;
      logic signed [7:0] dx;
      logic signed [7:0] dy;
      logic [9:0] features;
      logic [15:0] pix_sum;
      logic [5:0] bright;
   } mrr_frame_s;

endpackage

// [rtl/mrr_top.sv]
/*
 motion report registers: displacement accumulators, status byte,
 freeze-on-read snapshot, clear-on-read displacement, flush, and the
 per-frame quality, pixel sum and brightest pixel registers.
 assumes the serial front end and frame engine share clk_sys and give
 at most one register access per cycle.
*/
// Notes on behaviour
// [R1] status byte is readable at address 0x02
// [R2] pending bit is set while accumulated displacement is waiting
// [R3] overflow bit is set when either accumulator has overflowed
// [R4] status bit zero reports resolution: 0 is 400, 1 is 800 cpi
// [R5] reading status freezes X and Y into a snapshot
// [R6] a second status read overwrites the unread snapshot
// [R7] reader should fetch status, X, Y in sequence
// [R8] accumulators are wider than eight bits; overflow sets the flag
// [R9] overflow clears after a displacement read when not at full scale
// [R10] while overflowed data is pending, reports saturate at full scale
// [R11] reader repeats status, X, Y reads until pending clears
// [R12] any write to 0x12 discards all accumulated displacement
// [R13] X register at 0x03 is eight-bit signed and clears when read
// [R14] Y register at 0x04 is eight-bit signed and clears when read
// [R15] quality register at 0x05 is features over four, at most 169
// [R16] pixel sum register at 0x06 is upper sum byte, at most 221
// [R17] brightest register at 0x07 is six bits, upper two bits zero
// [R18] each frame outside power down adds its displacement; nonzero sets pending
`timescale 1ns/1ps

module mrr_top #(
   parameter int ACC_W = 13
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // register access from the serial front end
   input wire mrr_pkg::mrr_req_s req,
   output logic rd_valid,
   output logic [7:0] rd_data,
   // frame engine results
   input wire mrr_pkg::mrr_frame_s frame,
   // configuration and power state
   input wire logic cpi_select,
   input wire logic power_down_state
);

   ////////////////////////////////////////////////////////////////////
   // parameter check
   if (ACC_W < 9 || ACC_W > 24) begin : g_bad_width
      $error("mrr_top: ACC_W must be 9 to 24");
   end

   localparam int EW = ACC_W + 2;
   localparam logic signed [ACC_W-1:0] ACC_MAX =
      {1'b0, {(ACC_W-1){1'b1}}};
   localparam logic signed [ACC_W-1:0] ACC_MIN =
      {1'b1, {(ACC_W-1){1'b0}}};

   // clamp an accumulator to the eight-bit report range
   function automatic logic signed [7:0] clamp8(
      input logic signed [ACC_W-1:0] v);
      if (v > ACC_W'(mrr_pkg::DISP_MAX)) begin
         return mrr_pkg::DISP_MAX;
      end
      if (v < ACC_W'(mrr_pkg::DISP_MIN)) begin
         return mrr_pkg::DISP_MIN;
      end
      return v[7:0];
   endfunction

   // clamp a wide sum to the accumulator range
   function automatic logic signed [ACC_W-1:0] clamp_acc(
      input logic signed [EW-1:0] s);
      if (s > EW'(ACC_MAX)) begin
         return ACC_MAX;
      end
      if (s < EW'(ACC_MIN)) begin
         return ACC_MIN;
      end
      return s[ACC_W-1:0];
   endfunction

   // true when a wide sum left the accumulator range
   function automatic logic out_of_range(input logic signed [EW-1:0] s);
      return (s > EW'(ACC_MAX)) || (s < EW'(ACC_MIN));
   endfunction

   // true when an accumulator sits at either full scale
   function automatic logic at_full(input logic signed [ACC_W-1:0] v);
      return (v == ACC_MAX) || (v == ACC_MIN);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // access decode
   logic rd_status, rd_x, rd_y, wr_flush;
   assign rd_status = req.rd && (req.addr == mrr_pkg::ADDR_STATUS);
   assign rd_x = req.rd && (req.addr == mrr_pkg::ADDR_X_DISP);
   assign rd_y = req.rd && (req.addr == mrr_pkg::ADDR_Y_DISP);
   assign wr_flush = req.wr && (req.addr == mrr_pkg::ADDR_FLUSH); // R12

   ////////////////////////////////////////////////////////////////////
   // motion state
   logic signed [ACC_W-1:0] acc_x_r, acc_y_r, acc_x_nxt, acc_y_nxt;
   logic signed [7:0] snap_x_r, snap_y_r, snap_x_nxt, snap_y_nxt;
   logic pending_r, pending_nxt, ovf_r, ovf_nxt;
   logic signed [7:0] take_x, take_y;
   logic signed [EW-1:0] sum_x, sum_y;
   logic ovf_set, ovf_clr;

   // accumulate frames, hand out snapshots, track overflow
   always_comb begin
      take_x = rd_status ? clamp8(acc_x_r) : mrr_pkg::DISP_MIN; // R10
      take_y = rd_status ? clamp8(acc_y_r) : mrr_pkg::DISP_MIN; // R10
      sum_x = EW'(acc_x_r);
      sum_y = EW'(acc_y_r);
      if (rd_status) begin
         sum_x = sum_x - EW'(take_x); // R5
         sum_y = sum_y - EW'(take_y);
      end
      if (wr_flush || power_down_state) begin
         sum_x = '0; // R12
         sum_y = '0;
      end
      if (frame.valid && !power_down_state) begin
         sum_x = sum_x + EW'(frame.dx); // R18
         sum_y = sum_y + EW'(frame.dy);
      end
      ovf_set = out_of_range(sum_x) || out_of_range(sum_y); // R8
      acc_x_nxt = clamp_acc(sum_x); // R8
      acc_y_nxt = clamp_acc(sum_y);
      pending_nxt = (acc_x_nxt != '0) || (acc_y_nxt != '0); // R18
      // snapshot: status read overwrites, displacement read clears
      snap_x_nxt = snap_x_r;
      snap_y_nxt = snap_y_r;
      if (rd_status) begin
         snap_x_nxt = take_x; // R6
         snap_y_nxt = take_y;
      end
      if (rd_x) begin
         snap_x_nxt = '0; // R13
      end
      if (rd_y) begin
         snap_y_nxt = '0; // R14
      end
      if (wr_flush || power_down_state) begin
         snap_x_nxt = '0;
         snap_y_nxt = '0;
      end
      // a new overflow wins over any clear in the same cycle
      ovf_clr = ((rd_x || rd_y) && !at_full(acc_x_nxt)
                 && !at_full(acc_y_nxt)) // R9
                || wr_flush || power_down_state;
      ovf_nxt = ovf_set || (ovf_r && !ovf_clr); // R3
   end

   // motion state registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         acc_x_r <= '0;
         acc_y_r <= '0;
         snap_x_r <= '0;
         snap_y_r <= '0;
         pending_r <= 1'b0;
         ovf_r <= 1'b0;
      end else begin
         acc_x_r <= acc_x_nxt;
         acc_y_r <= acc_y_nxt;
         snap_x_r <= snap_x_nxt;
         snap_y_r <= snap_y_nxt;
         pending_r <= pending_nxt;
         ovf_r <= ovf_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // frame statistics
   logic [7:0] quality_r, quality_nxt, pix_sum_r, pix_sum_nxt;
   logic [5:0] bright_r, bright_nxt;

   // capture per-frame figures, quality and pixel sum clipped to their ceilings
   always_comb begin
      quality_nxt = quality_r;
      pix_sum_nxt = pix_sum_r;
      bright_nxt = bright_r;
      if (frame.valid) begin
         quality_nxt = (frame.features[9:2] > mrr_pkg::QUALITY_MAX)
            ? mrr_pkg::QUALITY_MAX : frame.features[9:2]; // R15
         pix_sum_nxt = (frame.pix_sum[15:8] > mrr_pkg::PIX_SUM_MAX)
            ? mrr_pkg::PIX_SUM_MAX : frame.pix_sum[15:8]; // R16
         bright_nxt = frame.bright; // R17
      end
   end

   // statistic registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         quality_r <= mrr_pkg::BYTE_ZERO;
         pix_sum_r <= mrr_pkg::BYTE_ZERO;
         bright_r <= '0;
      end else begin
         quality_r <= quality_nxt;
         pix_sum_r <= pix_sum_nxt;
         bright_r <= bright_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read data path
   logic [7:0] status_byte, rd_data_nxt;
   logic rd_valid_r;
   logic [7:0] rd_data_r;

   // status byte assembly, reserved bits zero
   always_comb begin
      status_byte = mrr_pkg::BYTE_ZERO;
      status_byte[mrr_pkg::BIT_PENDING] = pending_r; // R2
      status_byte[mrr_pkg::BIT_OVERFLOW] = ovf_r; // R3
      status_byte[mrr_pkg::BIT_CPI] = cpi_select; // R4
   end

   // read mux; unmapped and reserved addresses read zero
   always_comb begin
      unique case (req.addr)
         mrr_pkg::ADDR_STATUS: rd_data_nxt = status_byte; // R1
         mrr_pkg::ADDR_X_DISP: rd_data_nxt = snap_x_r; // R13
         mrr_pkg::ADDR_Y_DISP: rd_data_nxt = snap_y_r; // R14
         mrr_pkg::ADDR_QUALITY: rd_data_nxt = quality_r;
         mrr_pkg::ADDR_PIX_SUM: rd_data_nxt = pix_sum_r;
         mrr_pkg::ADDR_BRIGHT: rd_data_nxt =
            {mrr_pkg::BRIGHT_PAD, bright_r}; // R17
         default: rd_data_nxt = mrr_pkg::BYTE_ZERO;
      endcase
   end

   // read answer registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rd_valid_r <= 1'b0;
         rd_data_r <= mrr_pkg::BYTE_ZERO;
      end else begin
         rd_valid_r <= req.rd;
         rd_data_r <= req.rd ? rd_data_nxt : rd_data_r;
      end
   end

   assign rd_valid = rd_valid_r;
   assign rd_data = rd_data_r;

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   chk_status_read: assert property ( // R1
      rd_status |=> rd_valid && rd_data == $past(status_byte))
      else $error("status read answered wrongly");

   chk_pending_flag: assert property ( // R2
      pending_r == ((acc_x_r != '0) || (acc_y_r != '0)))
      else $error("pending flag disagrees with accumulators");

   chk_ovf_set: assert property ( // R3
      ovf_set |=> ovf_r ##0 (ovf_r || !$past(ovf_set)))
      else $error("overflow not flagged");

   chk_cpi_bit: assert property ( // R4
      rd_status |=> rd_data[mrr_pkg::BIT_CPI] == $past(cpi_select))
      else $error("resolution bit wrong");

   chk_snap_freeze: assert property ( // R5
      rd_status && !wr_flush && !power_down_state
      |=> snap_x_r == $past(clamp8(acc_x_r))
          && snap_y_r == $past(clamp8(acc_y_r)))
      else $error("snapshot not frozen on status read");

   chk_snap_hold: assert property ( // R6
      !req.rd && !req.wr && !power_down_state
      |=> $stable(snap_x_r) && $stable(snap_y_r))
      else $error("snapshot changed without access");

   chk_ovf_clear: assert property ( // R9
      ovf_r && rd_x && !ovf_set && !at_full(acc_x_nxt)
      && !at_full(acc_y_nxt) |=> !ovf_r)
      else $error("overflow did not clear after read");

   chk_sat_report: assert property ( // R10
      rd_status && !power_down_state
      && acc_x_r > ACC_W'(mrr_pkg::DISP_MAX)
      |=> snap_x_r == mrr_pkg::DISP_MAX)
      else $error("oversize X not saturated");

   chk_flush_all: assert property ( // R12
      wr_flush && !frame.valid
      |=> acc_x_r == '0 && acc_y_r == '0 && snap_x_r == '0
          && snap_y_r == '0 && !pending_r)
      else $error("flush left motion behind");

   chk_x_clear: assert property ( // R13
      rd_x |=> rd_data == $past(snap_x_r) && snap_x_r == '0)
      else $error("X read wrong or not cleared");

   chk_y_clear: assert property ( // R14
      rd_y |=> rd_data == $past(snap_y_r) && snap_y_r == '0)
      else $error("Y read wrong or not cleared");

   chk_quality_max: assert property ( // R15
      frame.valid |=> quality_r <= mrr_pkg::QUALITY_MAX
      && (quality_r == $past(frame.features[9:2])
          || quality_r == mrr_pkg::QUALITY_MAX))
      else $error("quality out of range");

   chk_pix_sum_max: assert property ( // R16
      frame.valid |=> pix_sum_r <= mrr_pkg::PIX_SUM_MAX)
      else $error("pixel sum out of range");

   chk_bright_pad: assert property ( // R17
      req.rd && req.addr == mrr_pkg::ADDR_BRIGHT
      |=> rd_data[7:6] == mrr_pkg::BRIGHT_PAD
          && rd_data[5:0] == $past(bright_r))
      else $error("brightest pixel read wrong");

   chk_frame_add: assert property ( // R18
      frame.valid && !req.rd && !req.wr && !power_down_state
      && !ovf_set |=> acc_x_r == $past(acc_x_r) + ACC_W'($past(frame.dx))
      ##0 pending_r == ((acc_x_r != '0) || (acc_y_r != '0)))
      else $error("frame displacement not accumulated");

   // reader accesses are spaced two cycles apart
   cov_status_pending: cover property (
      rd_status && pending_r ##2 rd_x ##2 rd_y);
   cov_overflow_recover: cover property (ovf_r ##[1:200] !ovf_r);
   cov_flush_pending: cover property (pending_r && wr_flush);
   cov_reread_discard: cover property (
      rd_status ##1 (!req.rd)[*3] ##1 rd_status);

endmodule

// [bench/mrr_reader.sv]
/*
 host reader model: drives the block's register port the way the
 host controller would, one access at a time.
 assumes the testbench calls its tasks one after another.
*/
`timescale 1ns/1ps

module mrr_reader (
   // clock
   input wire logic clk_sys,
   // register port toward the block
   output mrr_pkg::mrr_req_s req,
   input wire logic rd_valid,
   input wire logic [7:0] rd_data
);
   initial req = '0;

   ////////////////////////////////////////
   // one read, answer taken while rd_valid stands
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      req <= '{1'b1, 1'b0, a, 8'h00};
      @(posedge clk_sys);
      req <= '0;
      #1;
      while (rd_valid !== 1'b1 && n < 4) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      d = (rd_valid === 1'b1) ? rd_data : 8'hXX;
   endtask

   // one write pulse, no answer expected
   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      req <= '{1'b0, 1'b1, a, v};
      @(posedge clk_sys);
      req <= '0;
   endtask
endmodule

// [bench/tb_mrr_top.sv]
/*
 testbench for the motion report registers: reset values, movement,
 freeze, overflow drain, flush, power down and frame statistics.
 assumes mrr_reader owns the register port.
*/
`timescale 1ns/1ps

module tb_mrr_top;
   // small accumulator so overflow is quick: full scale +255/-256
   localparam int ACC_W = 9;
   localparam logic [6:0] ST = mrr_pkg::ADDR_STATUS;
   localparam logic [6:0] AX = mrr_pkg::ADDR_X_DISP;
   localparam logic [6:0] AY = mrr_pkg::ADDR_Y_DISP;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   mrr_pkg::mrr_req_s req;
   logic rd_valid;
   logic [7:0] rd_data;
   mrr_pkg::mrr_frame_s frame = '0;
   logic cpi_select = 1'b0;
   logic power_down_state = 1'b0;
   logic [9:0] feat_v = 10'h000;
   logic [15:0] pix_v = 16'h0000;
   logic [5:0] br_v = 6'h00;
   logic [7:0] d;
   int n_mismatch = 0;
   int checks = 0;
   int cyc = 0;

   // clock
   always #5 clk_sys = ~clk_sys;

   mrr_top #(.ACC_W(ACC_W)) i_mrr_top (.clk_sys(clk_sys), .rst(rst),
      .req(req), .rd_valid(rd_valid), .rd_data(rd_data), .frame(frame),
      .cpi_select(cpi_select), .power_down_state(power_down_state));

   mrr_reader i_mrr_reader (.clk_sys(clk_sys), .req(req),
      .rd_valid(rd_valid), .rd_data(rd_data));

   ////////////////////////////////////////
   // verdict and end of run
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // read a register and compare
   task automatic rdc(input logic [6:0] a, input logic [7:0] e);
      i_mrr_reader.rd(a, d);
      checks++;
      if (d !== e) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, d, e);
      end
   endtask

   // one frame result pulse
   task automatic put(input logic [7:0] dx, input logic [7:0] dy);
      @(posedge clk_sys);
      frame <= '{1'b1, dx, dy, feat_v, pix_v, br_v};
      @(posedge clk_sys);
      frame.valid <= 1'b0;
   endtask

   ////////////////////////////////////////
   // reset values, reserved and unmapped reads
   task automatic t_reset();
      for (int i = 2; i < 10; i++) begin
         rdc(7'(i), 8'h00);
      end
      rdc(7'h3F, 8'h00);
   endtask

   // resolution bit follows the live setting
   task automatic t_cpi();
      @(posedge clk_sys);
      cpi_select <= 1'b1;
      rdc(ST, 8'h01);
      @(posedge clk_sys);
      cpi_select <= 1'b0;
      rdc(ST, 8'h00);
   endtask

   // plain movement, clear on read
   task automatic t_motion();
      put(8'h05, 8'hFD);
      rdc(ST, 8'h80);
      rdc(AX, 8'h05);
      rdc(AY, 8'hFD);
      rdc(AX, 8'h00);
      rdc(AY, 8'h00);
      rdc(ST, 8'h00);
   endtask

   // snapshot frozen by status, overwritten by a second status
   task automatic t_freeze();
      put(8'h04, 8'h00);
      rdc(ST, 8'h80);
      put(8'h07, 8'h00);
      rdc(AX, 8'h04);
      rdc(AY, 8'h00);
      rdc(ST, 8'h80);
      rdc(AX, 8'h07);
      put(8'h02, 8'h00);
      rdc(ST, 8'h80);
      put(8'h03, 8'h00);
      rdc(ST, 8'h80);
      rdc(AX, 8'h03);
      rdc(ST, 8'h00);
   endtask

   // overflow both ways, then drain by repeated report cycles
   task automatic t_ovf();
      logic [7:0] es[3] = '{8'h90, 8'h80, 8'h80};
      logic [7:0] ex[3] = '{8'h7F, 8'h7F, 8'h01};
      logic [7:0] ey[3] = '{8'h80, 8'h80, 8'h00};
      repeat (3) put(8'h7F, 8'h80);
      for (int i = 0; i < 3; i++) begin
         rdc(ST, es[i]);
         rdc(AX, ex[i]);
         rdc(AY, ey[i]);
      end
      rdc(ST, 8'h00);
   endtask

   // flush clears stored motion, other writes are ignored
   task automatic t_flush();
      repeat (3) put(8'h7F, 8'h7F);
      i_mrr_reader.wr(mrr_pkg::ADDR_FLUSH, 8'h5A);
      rdc(ST, 8'h00);
      rdc(AX, 8'h00);
      put(8'h01, 8'h00);
      i_mrr_reader.wr(AX, 8'hFF);
      rdc(ST, 8'h80);
      i_mrr_reader.wr(mrr_pkg::ADDR_FLUSH, 8'h00);
      rdc(AX, 8'h00);
   endtask

   // power down drops stored motion and ignores frames, then resumes
   task automatic t_pd();
      put(8'h03, 8'h00);
      @(posedge clk_sys);
      power_down_state <= 1'b1;
      put(8'h05, 8'h05);
      @(posedge clk_sys);
      power_down_state <= 1'b0;
      rdc(ST, 8'h00);
      put(8'h02, 8'h00);
      rdc(ST, 8'h80);
      rdc(AX, 8'h02);
   endtask

   // frame statistics at, above and below their ceilings
   task automatic t_stats();
      feat_v = 10'h2A4;
      pix_v = 16'hDE00;
      br_v = 6'h3F;
      put(8'h00, 8'h00);
      rdc(mrr_pkg::ADDR_QUALITY, 8'hA9);
      rdc(mrr_pkg::ADDR_PIX_SUM, 8'hDD);
      rdc(mrr_pkg::ADDR_BRIGHT, 8'h3F);
      feat_v = 10'h2A8;
      pix_v = 16'h12AB;
      br_v = 6'h15;
      put(8'h00, 8'h00);
      rdc(mrr_pkg::ADDR_QUALITY, 8'hA9);
      rdc(mrr_pkg::ADDR_PIX_SUM, 8'h12);
      rdc(mrr_pkg::ADDR_BRIGHT, 8'h15);
   endtask

   ////////////////////////////////////////
   // hang guard
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_mismatch++;
         close_out();
      end
   end

   // main sequence
   initial begin
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset();
      t_cpi();
      t_motion();
      t_freeze();
      t_ovf();
      t_flush();
      t_pd();
      t_stats();
      close_out();
   end
endmodule
